// ### lsc_pkg.sv
// Constants, register map and state encoding of the latched SRAM controller.
// Assumes a 250 MHz system clock and an APB bus with 32-bit data.
package lsc_pkg;
  // Clock and device timing, in picoseconds
  localparam int CLK_PERIOD_PS = 4000;
  localparam int ACCESS_PS = 15000;
  localparam int WR_PULSE_PS = 15000;
  localparam int ALE_SETUP_PS = 4000;
  localparam int ALE_HOLD_PS = 2500;
  localparam int SLEEP_ENTRY_SETUP_PS = 100000;
  localparam int SLEEP_ENTRY_DELAY_PS = 1000000000;
  localparam int SLEEP_EXIT_DELAY_PS = 1000000000;
  localparam int SYNC_STAGES = 2;

  // Least times round up
  function automatic int cyc_min(input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int ACCESS_CYC = cyc_min(ACCESS_PS) + SYNC_STAGES;
  localparam int WR_PULSE_CYC = cyc_min(WR_PULSE_PS);
  localparam int ALE_SETUP_CYC = cyc_min(ALE_SETUP_PS);
  localparam int ALE_HOLD_CYC = cyc_min(ALE_HOLD_PS);
  localparam int SLEEP_SETUP_CYC = cyc_min(SLEEP_ENTRY_SETUP_PS);
  localparam int SLEEP_ENTRY_CYC = cyc_min(SLEEP_ENTRY_DELAY_PS);
  localparam int SLEEP_EXIT_CYC = cyc_min(SLEEP_EXIT_DELAY_PS);

  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int CNT_W = 18;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] ADDR_OFS = 8'h04;
  localparam logic [7:0] WDATA_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam logic [7:0] RDATA_OFS = 8'h10;

  // Control fields
  localparam int CTRL_GO = 0;
  localparam int CTRL_WRITE = 1;
  localparam int CTRL_SLEEP = 2;
  localparam int CTRL_LATCH = 3;
  localparam int CTRL_LOW_EN = 4;
  localparam int CTRL_HIGH_EN = 5;
  localparam logic [5:0] CTRL_RESET = 6'h30;

  // Status fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_SLEEPING = 1;
  localparam int STAT_DONE = 2;
  localparam int STAT_SINGLE = 3;
  localparam int STAT_MULTI = 4;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_SETUP = 4'h1,
    ST_LATCH = 4'h2,
    ST_ACT = 4'h3,
    ST_RECOV = 4'h4,
    ST_DONE = 4'h5,
    ST_SLP_SETUP = 4'h6,
    ST_SLP_ENTER = 4'h7,
    ST_SLEEP = 4'h8,
    ST_SLP_EXIT = 4'h9
  } lsc_state_type;
endpackage

// ### lsc_ctrl.sv
// Host controller for a latched-address asynchronous static memory with per-byte ECC.
// Assumes APB software access on sys_clk, and that the memory and pins sit outside the clock.
`timescale 1ns/1ns

// Summary of operation
// - After latching, the host may reuse address and chip select lines.
// - The host never drives the data pins during a read access.
// - Sleep request goes low only after chip select was high 100 ns.
// - During sleep the host holds chip select high and sleep request low.
// - Exit by raising sleep request; reselect only 1 ms later.
// - The host may watch either error flag; an unused one may float.
// - A write lasts while chip select, a byte enable and write enable overlap.
module lsc_ctrl #(
  parameter int SLEEP_ENTRY_CYC = lsc_pkg::SLEEP_ENTRY_CYC,
  parameter int SLEEP_EXIT_CYC = lsc_pkg::SLEEP_EXIT_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Memory control pins
  output logic addr_latch_en_n,
  output logic chip_sel_n,
  output logic write_en_n,
  output logic output_en_n,
  output logic low_byte_en_n,
  output logic high_byte_en_n,
  output logic sleep_req_n,
  output logic [lsc_pkg::ADDR_W-1:0] addr_in,
  // Memory data pins, output enable low while driving
  input wire logic [lsc_pkg::DATA_W-1:0] data_in,
  output logic [lsc_pkg::DATA_W-1:0] data_out,
  output logic data_oe_n,
  // Memory error flags
  input wire logic single_err_flag,
  input wire logic multi_err_flag
);
  localparam int AW = lsc_pkg::ADDR_W;
  localparam int DW = lsc_pkg::DATA_W;
  localparam int CW = lsc_pkg::CNT_W;

  if (SLEEP_ENTRY_CYC < 1 || SLEEP_ENTRY_CYC >= (1 << CW) ||
      SLEEP_EXIT_CYC < 1 || SLEEP_EXIT_CYC >= (1 << CW)) begin : g_bad_param
    $error("sleep delay counts out of range");
  end

  function automatic logic [CW-1:0] load(input int cyc);
    return CW'(cyc - 1);
  endfunction

  // Strobe length of the access phase
  function automatic logic [CW-1:0] act_load(input logic wr);
    return wr ? load(lsc_pkg::WR_PULSE_CYC) : load(lsc_pkg::ACCESS_CYC);
  endfunction

  lsc_pkg::lsc_state_type state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [5:0] ctrl_q;
  logic go_q;
  logic [AW-1:0] addr_q;
  logic [DW-1:0] wdata_q;
  logic [DW-1:0] rdata_q;
  logic single_q, multi_q;
  logic done_q;
  logic [DW-1:0] din_s1_q, din_s2_q;
  logic [1:0] err_s1_q, err_s2_q;
  logic prdy_q, perr_q;
  logic [31:0] prd_q;
  logic cnt_zero;
  logic capture;
  logic apb_wr;
  logic done_clr;

  assign cnt_zero = (cnt_q == '0);
  assign apb_wr = psel && penable && pready && pwrite;
  assign done_clr = apb_wr && (paddr == lsc_pkg::STATUS_OFS) && pwdata[lsc_pkg::STAT_DONE];
  // Flags share the data path sync depth, so both are sampled together
  assign capture = (state_q == lsc_pkg::ST_ACT) && !ctrl_q[lsc_pkg::CTRL_WRITE] && cnt_zero;

  // Pin inputs pass two flip-flops; flags float outside reads and are only used at capture
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      din_s1_q <= '0;
      din_s2_q <= '0;
      err_s1_q <= '0;
      err_s2_q <= '0;
    end else begin
      din_s1_q <= data_in;
      din_s2_q <= din_s1_q;
      err_s1_q <= {multi_err_flag, single_err_flag};
      err_s2_q <= err_s1_q;
    end
  end

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_zero ? cnt_q : cnt_q - CW'(1);
    case (state_q)
      lsc_pkg::ST_IDLE: begin
        if (ctrl_q[lsc_pkg::CTRL_SLEEP]) begin
          state_d = lsc_pkg::ST_SLP_SETUP;
          cnt_d = load(lsc_pkg::SLEEP_SETUP_CYC);
        end else if (go_q) begin
          state_d = lsc_pkg::ST_SETUP;
          cnt_d = load(lsc_pkg::ALE_SETUP_CYC);
        end
      end
      lsc_pkg::ST_SETUP: begin
        if (cnt_zero) begin
          if (ctrl_q[lsc_pkg::CTRL_LATCH]) begin
            state_d = lsc_pkg::ST_LATCH;
            cnt_d = load(lsc_pkg::ALE_HOLD_CYC);
          end else begin
            state_d = lsc_pkg::ST_ACT;
            cnt_d = act_load(ctrl_q[lsc_pkg::CTRL_WRITE]);
          end
        end
      end
      lsc_pkg::ST_LATCH: begin
        if (cnt_zero) begin
          state_d = lsc_pkg::ST_ACT;
          cnt_d = act_load(ctrl_q[lsc_pkg::CTRL_WRITE]);
        end
      end
      lsc_pkg::ST_ACT: begin
        if (cnt_zero) begin
          state_d = ctrl_q[lsc_pkg::CTRL_WRITE] ? lsc_pkg::ST_RECOV : lsc_pkg::ST_DONE;
        end
      end
      lsc_pkg::ST_RECOV: state_d = lsc_pkg::ST_DONE;
      lsc_pkg::ST_DONE: state_d = lsc_pkg::ST_IDLE;
      lsc_pkg::ST_SLP_SETUP: begin
        if (!ctrl_q[lsc_pkg::CTRL_SLEEP]) begin
          state_d = lsc_pkg::ST_IDLE;
        end else if (cnt_zero) begin
          state_d = lsc_pkg::ST_SLP_ENTER;
          cnt_d = load(SLEEP_ENTRY_CYC);
        end
      end
      lsc_pkg::ST_SLP_ENTER: begin
        if (cnt_zero) begin
          state_d = lsc_pkg::ST_SLEEP;
        end
      end
      lsc_pkg::ST_SLEEP: begin
        if (!ctrl_q[lsc_pkg::CTRL_SLEEP]) begin
          state_d = lsc_pkg::ST_SLP_EXIT;
          cnt_d = load(SLEEP_EXIT_CYC);
        end
      end
      lsc_pkg::ST_SLP_EXIT: begin
        // No reselect until the exit delay has run out
        if (cnt_zero) begin
          state_d = lsc_pkg::ST_IDLE;
        end
      end
      default: state_d = lsc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_q <= lsc_pkg::ST_IDLE;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // Pins are decoded from the next state so each comes straight from a flip-flop
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      addr_latch_en_n <= 1'b1;
      chip_sel_n <= 1'b1;
      write_en_n <= 1'b1;
      output_en_n <= 1'b1;
      low_byte_en_n <= 1'b1;
      high_byte_en_n <= 1'b1;
      sleep_req_n <= 1'b1;
      addr_in <= '0;
      data_out <= '0;
      data_oe_n <= 1'b1;
    end else begin
      case (state_d)
        lsc_pkg::ST_SETUP, lsc_pkg::ST_LATCH, lsc_pkg::ST_ACT, lsc_pkg::ST_RECOV: begin
          // Address and select settle with latch enable high, then fall to capture them
          addr_latch_en_n <= (state_d == lsc_pkg::ST_SETUP) || !ctrl_q[lsc_pkg::CTRL_LATCH];
          // Lines stay driven after latching although the memory holds them
          chip_sel_n <= 1'b0;
          addr_in <= addr_q;
          // Byte enables select the lanes written or driven
          low_byte_en_n <= !ctrl_q[lsc_pkg::CTRL_LOW_EN];
          high_byte_en_n <= !ctrl_q[lsc_pkg::CTRL_HIGH_EN];
          // Write enable falls last and rises first inside select and bytes
          write_en_n <= !(ctrl_q[lsc_pkg::CTRL_WRITE] && state_d == lsc_pkg::ST_ACT);
          // Output enable stays high on writes and low only in a read
          output_en_n <= !(!ctrl_q[lsc_pkg::CTRL_WRITE] && state_d == lsc_pkg::ST_ACT);
          // Data driven only for writes, held one cycle past write end
          data_oe_n <= !ctrl_q[lsc_pkg::CTRL_WRITE];
          data_out <= wdata_q;
          sleep_req_n <= 1'b1;
        end
        default: begin
          // Deselected standby between accesses
          addr_latch_en_n <= 1'b1;
          chip_sel_n <= 1'b1;
          write_en_n <= 1'b1;
          output_en_n <= 1'b1;
          low_byte_en_n <= 1'b1;
          high_byte_en_n <= 1'b1;
          data_oe_n <= 1'b1;
          // Sleep request low only after the setup wait, held low through sleep
          sleep_req_n <= !(state_d == lsc_pkg::ST_SLP_ENTER || state_d == lsc_pkg::ST_SLEEP);
        end
      endcase
    end
  end

  // Read data and error result of the last read
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rdata_q <= '0;
      single_q <= 1'b0;
      multi_q <= 1'b0;
    end else if (capture) begin
      // Disabled lanes float, so they read back as zero
      rdata_q <= din_s2_q & {{8{ctrl_q[lsc_pkg::CTRL_HIGH_EN]}},
                             {8{ctrl_q[lsc_pkg::CTRL_LOW_EN]}}};
      // Flags are only valid during a read with outputs on
      single_q <= err_s2_q[0];
      multi_q <= err_s2_q[1];
    end
  end

  // Sticky completion flag; a new completion beats a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      done_q <= 1'b0;
    end else if (state_q == lsc_pkg::ST_DONE) begin
      done_q <= 1'b1;
    end else if (done_clr) begin
      done_q <= 1'b0;
    end
  end

  // Software registers
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ctrl_q <= lsc_pkg::CTRL_RESET;
      go_q <= 1'b0;
      addr_q <= '0;
      wdata_q <= '0;
    end else begin
      if (state_q == lsc_pkg::ST_IDLE) begin
        go_q <= 1'b0;
      end
      if (apb_wr) begin
        case (paddr)
          lsc_pkg::CTRL_OFS: begin
            ctrl_q <= {pwdata[lsc_pkg::CTRL_HIGH_EN:lsc_pkg::CTRL_WRITE], 1'b0};
            if (state_q == lsc_pkg::ST_IDLE && !pwdata[lsc_pkg::CTRL_SLEEP]) begin
              go_q <= pwdata[lsc_pkg::CTRL_GO];
            end
          end
          lsc_pkg::ADDR_OFS: addr_q <= pwdata[AW-1:0];
          lsc_pkg::WDATA_OFS: wdata_q <= pwdata[DW-1:0];
          default: ;
        endcase
      end
    end
  end

  // APB answer: no wait states, registered data and error
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      prdy_q <= 1'b0;
      perr_q <= 1'b0;
      prd_q <= '0;
    end else if (psel && !penable && !prdy_q) begin
      prdy_q <= 1'b1;
      perr_q <= 1'b0;
      prd_q <= '0;
      case (paddr)
        lsc_pkg::CTRL_OFS: prd_q <= {26'h0, ctrl_q};
        lsc_pkg::ADDR_OFS: prd_q <= {14'h0, addr_q};
        lsc_pkg::WDATA_OFS: prd_q <= {16'h0, wdata_q};
        lsc_pkg::STATUS_OFS: begin
          prd_q[lsc_pkg::STAT_BUSY] <= (state_q != lsc_pkg::ST_IDLE) || go_q;
          prd_q[lsc_pkg::STAT_SLEEPING] <= (state_q == lsc_pkg::ST_SLEEP);
          prd_q[lsc_pkg::STAT_DONE] <= done_q;
          prd_q[lsc_pkg::STAT_SINGLE] <= single_q;
          prd_q[lsc_pkg::STAT_MULTI] <= multi_q;
        end
        lsc_pkg::RDATA_OFS: prd_q <= {16'h0, rdata_q};
        default: perr_q <= 1'b1;
      endcase
    end else begin
      prdy_q <= 1'b0;
      perr_q <= 1'b0;
    end
  end

  assign pready = prdy_q;
  assign pslverr = perr_q;
  assign prdata = prd_q;
endmodule

// ### lsc_sram_model.sv
// Behavioural latched static memory with single and multi-bit error flags, on the controller's pins.
// Assumes the bench resolves the data wire and commands error results through err_mode.
`timescale 1ns/1ns
module lsc_sram_model #(
  parameter int ENTRY_NS = 80
) (
  // Control pins
  input wire logic addr_latch_en_n,
  input wire logic chip_sel_n,
  input wire logic write_en_n,
  input wire logic output_en_n,
  input wire logic low_byte_en_n,
  input wire logic high_byte_en_n,
  input wire logic sleep_req_n,
  input wire logic [17:0] addr_in,
  // Data wire level and own drive
  input wire logic [15:0] pin_level,
  output logic [15:0] drive_val,
  output logic [1:0] drive_en,
  // Error result, bit0 single, bit1 multi
  input wire logic [1:0] err_mode,
  output logic single_err_flag,
  output logic multi_err_flag
);
  logic [15:0] mem [0:262143];
  logic [17:0] lat_addr;
  logic lat_cs_n;
  logic asleep = 1'b0;
  logic awake_zz;
  logic rd_on;
  assign awake_zz = (sleep_req_n !== 1'b0);
  always_latch begin
    if (addr_latch_en_n) begin
      lat_addr = addr_in;
      lat_cs_n = chip_sel_n;
    end
  end
  always @(awake_zz) begin
    asleep = 1'b0;
    if (!awake_zz) begin
      #(ENTRY_NS);
      asleep = !awake_zz;
    end
  end
  // Store while select, a byte enable and write strobe overlap
  always @(lat_cs_n, write_en_n, low_byte_en_n, high_byte_en_n, pin_level, lat_addr) begin
    if (!lat_cs_n && !write_en_n && !asleep) begin
      if (!low_byte_en_n) mem[lat_addr][7:0] = pin_level[7:0];
      if (!high_byte_en_n) mem[lat_addr][15:8] = pin_level[15:8];
    end
  end
  assign rd_on = !lat_cs_n && write_en_n && !output_en_n && !asleep;
  assign drive_en = rd_on ? {~high_byte_en_n, ~low_byte_en_n} : 2'b00;
  // A multi-bit result hands out invalid data
  assign drive_val = err_mode[1] ? ~mem[lat_addr] : mem[lat_addr];
  assign single_err_flag = rd_on ? err_mode[0] : 1'bz;
  assign multi_err_flag = rd_on ? err_mode[1] : 1'bz;
endmodule

// ### lsc_ctrl_assertions.sv
// Checker on the memory-side pins of the latched SRAM controller.
// Assumes it is bound to lsc_ctrl; rstn is synchronous and active low.
`timescale 1ns/1ns
module lsc_ctrl_chk #(
  parameter int SLEEP_EXIT_CYC = lsc_pkg::SLEEP_EXIT_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Memory pins
  input wire logic addr_latch_en_n,
  input wire logic chip_sel_n,
  input wire logic write_en_n,
  input wire logic output_en_n,
  input wire logic low_byte_en_n,
  input wire logic high_byte_en_n,
  input wire logic sleep_req_n,
  input wire logic [lsc_pkg::ADDR_W-1:0] addr_in,
  input wire logic data_oe_n
);
  localparam int SETUP_CYC = lsc_pkg::SLEEP_SETUP_CYC;
  logic [17:0] cs_hi_q;
  logic [17:0] zz_hi_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  always_ff @(posedge sys_clk) begin
    if (!rstn || !chip_sel_n) cs_hi_q <= 18'h0;
    else if (cs_hi_q != 18'h3ffff) cs_hi_q <= cs_hi_q + 18'h1;
  end
  // Starts saturated so the first access after reset is legal
  always_ff @(posedge sys_clk) begin
    if (!rstn) zz_hi_q <= 18'h3ffff;
    else if (!sleep_req_n) zz_hi_q <= 18'h0;
    else if (zz_hi_q != 18'h3ffff) zz_hi_q <= zz_hi_q + 18'h1;
  end
  sequence we_pulse_s; !write_en_n [*4] ##1 write_en_n; endsequence
  sequence oe_pulse_s; !output_en_n [*6] ##1 output_en_n; endsequence
  wr_pulse_len_a: assert property ($fell(write_en_n) |-> we_pulse_s)
    else $error("write strobe length wrong");
  rd_pulse_len_a: assert property ($fell(output_en_n) |-> oe_pulse_s)
    else $error("output enable pulse length wrong");
  wr_window_a: assert property (!write_en_n |-> !chip_sel_n && !data_oe_n
    && !(low_byte_en_n && high_byte_en_n)) else $error("write strobe outside write window");
  wr_hold_a: assert property ($rose(write_en_n) |-> !data_oe_n ##1 data_oe_n)
    else $error("write data not held past strobe");
  no_contend_a: assert property (!chip_sel_n && write_en_n && !output_en_n
    |-> data_oe_n) else $error("host drives data during read");
  ale_capture_a: assert property ($fell(addr_latch_en_n) |->
    !$past(chip_sel_n) && $stable(addr_in)) else $error("latch edge without valid address");
  ale_hold_a: assert property ($fell(addr_latch_en_n) |-> ##1 !addr_latch_en_n
    && (!output_en_n || !write_en_n)) else $error("latch released before access");
  sleep_setup_a: assert property ($fell(sleep_req_n) |-> cs_hi_q >= SETUP_CYC)
    else $error("sleep request too soon after deselect");
  sleep_cs_a: assert property (!sleep_req_n |-> chip_sel_n)
    else $error("select active during sleep");
  exit_wait_a: assert property ($fell(chip_sel_n) |-> zz_hi_q >= SLEEP_EXIT_CYC)
    else $error("select too soon after sleep exit");
endmodule

// ### latched_addr_ecc_async_sram_tb.sv
// Self-checking bench of the latched SRAM controller with a memory model on its pins.
// Assumes lsc_pkg, lsc_ctrl, lsc_sram_model and lsc_ctrl_assertions are compiled first.
`timescale 1ns/1ns
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin bad_count++; \
  $display("unexpected at %0t: got %h want %h", $time, got, exp); end end
module latched_addr_ecc_async_sram_tb;
  logic sys_clk, rstn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, st;
  logic ale_n, cs_n, we_n, oe_n, lb_n, ub_n, zz_n, data_oe_n, s_flag, m_flag;
  logic [17:0] addr;
  logic [15:0] data_out, drive_val, pin_level;
  logic [15:0] float_val = 16'h0000;
  logic [1:0] drive_en, err_mode;
  int bad_count = 0;
  int n_tests = 0;
  // Undriven lanes change every cycle
  always @(posedge sys_clk) float_val <= ~pin_level;
  assign pin_level[7:0] = !data_oe_n ? data_out[7:0] : drive_en[0] ? drive_val[7:0] :
    float_val[7:0];
  assign pin_level[15:8] = !data_oe_n ? data_out[15:8] : drive_en[1] ? drive_val[15:8] :
    float_val[15:8];
  lsc_ctrl #(.SLEEP_ENTRY_CYC(20), .SLEEP_EXIT_CYC(20)) i_lsc_ctrl (.sys_clk(sys_clk),
    .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .addr_latch_en_n(ale_n), .chip_sel_n(cs_n), .write_en_n(we_n), .output_en_n(oe_n),
    .low_byte_en_n(lb_n), .high_byte_en_n(ub_n), .sleep_req_n(zz_n), .addr_in(addr),
    .data_in(pin_level), .data_out(data_out), .data_oe_n(data_oe_n),
    .single_err_flag(s_flag), .multi_err_flag(m_flag));
  lsc_sram_model #(.ENTRY_NS(80)) i_lsc_sram_model (.addr_latch_en_n(ale_n),
    .chip_sel_n(cs_n), .write_en_n(we_n), .output_en_n(oe_n), .low_byte_en_n(lb_n),
    .high_byte_en_n(ub_n), .sleep_req_n(zz_n), .addr_in(addr), .pin_level(pin_level),
    .drive_val(drive_val), .drive_en(drive_en), .err_mode(err_mode),
    .single_err_flag(s_flag), .multi_err_flag(m_flag));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic test_done;
    $display("Checks: %0d, mismatches: %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r, output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, er);
  endtask
  task automatic wait_stat(input logic [31:0] mask, input logic [31:0] val);
    int n;
    n = 0;
    do begin
      apb(1'b0, lsc_pkg::STATUS_OFS, 32'h0, st, er);
      n++;
    end while ((st & mask) !== val && n < 60);
    if (n >= 60) begin
      bad_count++;
      test_done;
    end
  endtask
  task automatic access(input logic w, input logic lat, input logic [1:0] be,
                        input logic [17:0] a, input logic [15:0] d);
    wr32(lsc_pkg::ADDR_OFS, {14'h0, a});
    wr32(lsc_pkg::WDATA_OFS, {16'h0, d});
    wr32(lsc_pkg::CTRL_OFS, {26'h0, be, lat, 1'b0, w, 1'b1});
    wait_stat(32'h4, 32'h4);
    wr32(lsc_pkg::STATUS_OFS, 32'h4);
    apb(1'b0, lsc_pkg::RDATA_OFS, 32'h0, rd, er);
  endtask
  function automatic logic [15:0] lanes(input logic [15:0] v, input logic [1:0] be);
    return {be[1] ? v[15:8] : 8'h00, be[0] ? v[7:0] : 8'h00};
  endfunction
  initial begin
    #100000;
    bad_count++;
    test_done;
  end
  initial begin
    logic [17:0] a;
    logic [15:0] d0, d1, e;
    logic [1:0] be;
    {rstn, psel, penable, pwrite, paddr, pwdata, err_mode} = '0;
    void'($urandom(32'h1fe9));
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    apb(1'b0, lsc_pkg::CTRL_OFS, 32'h0, rd, er);
    `CHK(rd, 32'h30)
    apb(1'b0, 8'h20, 32'h0, rd, er);
    `CHK(er, 1'b1)
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 18'h3ffff : 18'($urandom);
      d0 = 16'($urandom);
      d1 = 16'($urandom);
      be = 2'(i % 3 + 1);
      access(1'b1, i[0], 2'b11, a, d0);
      access(1'b1, i[1], be, a, d1);
      e = (d0 & ~lanes(16'hffff, be)) | lanes(d1, be);
      access(1'b0, i[0], 2'b11, a, 16'h0);
      `CHK(rd[15:0], e)
      access(1'b0, 1'b1, be, a, 16'h0);
      `CHK(rd[15:0], lanes(e, be))
    end
    for (int m = 0; m < 4; m++) begin
      err_mode <= 2'(m);
      access(1'b0, 1'b0, 2'b11, a, 16'h0);
      `CHK(st[4:3], 2'(m))
      if (m < 2) `CHK(rd[15:0], e)
    end
    err_mode <= 2'b00;
    // Reset in mid run returns registers and pins to idle
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    apb(1'b0, lsc_pkg::STATUS_OFS, 32'h0, st, er);
    `CHK(st, 32'h0)
    `CHK({cs_n, zz_n, data_oe_n}, 3'b111)
    wr32(lsc_pkg::CTRL_OFS, 32'h34);
    wait_stat(32'h2, 32'h2);
    `CHK(i_lsc_sram_model.asleep, 1'b1)
    `CHK(zz_n, 1'b0)
    wr32(lsc_pkg::CTRL_OFS, 32'h30);
    wait_stat(32'h3, 32'h0);
    repeat (22) @(posedge sys_clk);
    access(1'b0, 1'b1, 2'b11, a, 16'h0);
    `CHK(rd[15:0], e)
    `CHK(addr, a)
    test_done;
  end
endmodule
bind lsc_ctrl lsc_ctrl_chk #(.SLEEP_EXIT_CYC(SLEEP_EXIT_CYC)) i_lsc_ctrl_chk (
  .sys_clk(sys_clk), .rstn(rstn), .addr_latch_en_n(addr_latch_en_n),
  .chip_sel_n(chip_sel_n), .write_en_n(write_en_n), .output_en_n(output_en_n),
  .low_byte_en_n(low_byte_en_n), .high_byte_en_n(high_byte_en_n),
  .sleep_req_n(sleep_req_n), .addr_in(addr_in), .data_oe_n(data_oe_n));
